// ===== rtl/ic_line_if.sv
// Synchronised bus line levels and conditions passed to the engine
`default_nettype none
interface ic_line_if;
  logic scl, sda, scl_rise, scl_fall, start_seen, stop_seen, busy;
  modport mon (output scl, sda, scl_rise, scl_fall, start_seen, stop_seen, busy);
  modport eng (input scl, sda, scl_rise, scl_fall, start_seen, stop_seen, busy);
endinterface : ic_line_if
`default_nettype wire

// ===== rtl/ic_line_mon.sv
// Two-stage synchronisers and edge, start, stop and busy detection on the bus lines
`default_nettype none
module ic_line_mon (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Raw pins
  input wire logic scl_in,
  input wire logic sda_in,
  // Line events
  ic_line_if.mon ln
);
  import ic_pkg::*;
  ic_mon_s r;
  ic_mon_s next_r;
  // Only the second and third stages are looked at
  always_comb begin
    next_r = r;
    next_r.scl_m = scl_in;
    next_r.scl_s = r.scl_m;
    next_r.scl_p = r.scl_s;
    next_r.sda_m = sda_in;
    next_r.sda_s = r.sda_m;
    next_r.sda_p = r.sda_s;
    if (ln.start_seen) begin
      next_r.busy = 1'b1;
    end else if (ln.stop_seen) begin
      next_r.busy = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
             busy: 1'b0};
    end else begin
      r <= next_r;
    end
  end
  assign ln.scl = r.scl_s;
  assign ln.sda = r.sda_s;
  assign ln.scl_rise = r.scl_s && !r.scl_p;
  assign ln.scl_fall = !r.scl_s && r.scl_p;
  assign ln.start_seen = r.scl_s && r.scl_p && r.sda_p && !r.sda_s;
  assign ln.stop_seen = r.scl_s && r.scl_p && !r.sda_p && r.sda_s;
  assign ln.busy = r.busy;
endmodule : ic_line_mon
`default_nettype wire

// ===== rtl/ic_pkg.sv
// Types shared by the I2C engine modules
`default_nettype none
package ic_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_STOP, ST_XFER, ST_HOLD, ST_SETUP} ic_state_e;
  typedef struct packed {
    logic [15:0] cnt;
  } ic_tmr_s;
  typedef struct packed {
    logic scl_m, scl_s, scl_p;
    logic sda_m, sda_s, sda_p;
    logic busy;
  } ic_mon_s;
  typedef struct packed {
    ic_state_e fsm;
    logic [1:0] ph;
    logic mst, tx, adr, addr_d, gcall, arb, last, ackd, mrx, rep, tclr;
    logic [3:0] bc;
    logic [7:0] sh;
    logic scl_drv, sda_drv;
    logic en, begin_condition_request, halt_condition_request, si, aa;
    logic [7:0] stat, dat, own;
    logic [15:0] thi, tlo, rdata;
  } ic_eng_s;
endpackage : ic_pkg
`default_nettype wire

// ===== rtl/ic_regs.svh
// Register map, field positions, reset values, status codes and timing of the I2C engine
//
// How it works
// [RQ1] Answer the 7-bit own address; general call only when its enable bit is set.
// [RQ2] Software enables the block, sets ack-assert, leaves start, stop and flag clear.
// [RQ3] Slave behaviour never depends on the master clock high and low periods.
// [RQ4] Own address with write bit enters slave receive, sets flag and status.
// [RQ5] Arbitration lost then addressed for write gives slave receive, status 0x68 or 0x78.
// [RQ6] Ack-assert cleared in slave receive: not-acknowledge after the next data byte.
// [RQ7] Ack-assert clear: ignore own and general call address, keep watching the bus.
// [RQ8] Own address with read bit enters slave transmit, sets flag and status.
// [RQ9] Arbitration lost then addressed for read gives slave transmit, status 0xB0.
// [RQ10] Ack-assert cleared in slave transmit: last byte, 0xC0 or 0xC8, then release.
// [RQ11] After repeated start, address with read bit switches to master receive.
// [RQ12] At 0x18 software loads data; the byte is sent and its acknowledge sampled.
// [RQ13] At 0x20 the same four answers as at 0x18 are accepted.
// [RQ14] At 0x28 and 0x30 send data, repeated start, stop, or stop then start.
// [RQ15] Stop request sends a stop condition, then hardware clears the stop request.
// [RQ16] Start and stop requests together send a stop followed at once by a start.
// [RQ17] At 0x38 release the bus; with start request, start once the bus is free.
// [RQ18] A sent start condition sets the flag with status 0x08.
// [RQ19] Transfer stays suspended until software clears the interrupt flag.
// [RQ20] While the flag is set the serial clock line is held low; at status 0x38 and 0xA0 the code leaves the clock line released.
`ifndef IC_REGS_SVH
`define IC_REGS_SVH
`define IC_OFS_CTL_SET 5'h00
`define IC_OFS_STAT 5'h04
`define IC_OFS_DATA 5'h08
`define IC_OFS_OWN 5'h0C
`define IC_OFS_SCLH 5'h10
`define IC_OFS_SCLL 5'h14
`define IC_OFS_CTL_CLR 5'h18
`define IC_BIT_EN 6
`define IC_BIT_STA 5
`define IC_BIT_STO 4
`define IC_BIT_SI 3
`define IC_BIT_AA 2
`define IC_BIT_GC 0
`define IC_RST_OWN 8'h00
`define IC_RST_SCL 16'h0271
`define IC_GC_ADDR 7'h00
`define IC_STAT_IDLE 8'hF8
`define IC_ST_08 8'h08
`define IC_ST_10 8'h10
`define IC_ST_18 8'h18
`define IC_ST_20 8'h20
`define IC_ST_28 8'h28
`define IC_ST_30 8'h30
`define IC_ST_38 8'h38
`define IC_ST_40 8'h40
`define IC_ST_48 8'h48
`define IC_ST_50 8'h50
`define IC_ST_58 8'h58
`define IC_ST_60 8'h60
`define IC_ST_68 8'h68
`define IC_ST_70 8'h70
`define IC_ST_78 8'h78
`define IC_ST_80 8'h80
`define IC_ST_88 8'h88
`define IC_ST_90 8'h90
`define IC_ST_98 8'h98
`define IC_ST_A0 8'hA0
`define IC_ST_A8 8'hA8
`define IC_ST_B0 8'hB0
`define IC_ST_B8 8'hB8
`define IC_ST_C0 8'hC0
`define IC_ST_C8 8'hC8
`define IC_CLK_MHZ 125
`define IC_TSU_NS 250
`define IC_TSU_CYC (((`IC_TSU_NS * `IC_CLK_MHZ) + 999) / 1000)
`endif

// ===== rtl/ic_timer.sv
// Free counter for bus phase timing, cleared by the engine on every phase change
`default_nettype none
module ic_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic clr,
  input wire logic [15:0] lim,
  output logic done
);
  import ic_pkg::*;
  ic_tmr_s r;
  ic_tmr_s next_r;
  // Saturates so a long stall never wraps back below the limit
  always_comb begin
    next_r = r;
    if (clr) begin
      next_r.cnt = 16'h0000;
    end else if (r.cnt != 16'hFFFF) begin
      next_r.cnt = r.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign done = (r.cnt >= lim);
endmodule : ic_timer
`default_nettype wire

// ===== rtl/ic_top.sv
// I2C byte engine: register port, master and slave sequencing, open-drain line drive
`default_nettype none
`include "ic_regs.svh"
module ic_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Serial clock pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Serial data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import ic_pkg::*;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic [1:0] rst_q;
  logic rst_n_s;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n_s = rst_q[1];

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  ic_eng_s r;
  ic_eng_s next_r;
  ic_line_if ln ();
  logic t_done;
  logic tdone;
  logic [15:0] lim;
  logic [1:0] hit;

  ic_line_mon u_mon (
    .clk_sys(clk_sys),
    .rst_n(rst_n_s),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ln(ln)
  );

  ic_timer u_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n_s),
    .clr(r.tclr),
    .lim(lim),
    .done(t_done)
  );

  // Returns {general call hit, own address hit}
  function automatic logic [1:0] ic_match(input logic [7:0] rx, input logic [7:0] own,
                                          input logic aa);
    logic gc_hit;
    logic own_hit;
    gc_hit = aa && own[`IC_BIT_GC] && (rx[7:1] == `IC_GC_ADDR) && !rx[0];
    own_hit = aa && (rx[7:1] == own[7:1]);
    ic_match = {gc_hit, own_hit};
  endfunction : ic_match

  // Slave setup uses a fixed time, never the master periods
  always_comb begin
    if (r.fsm == ST_SETUP) begin
      lim = 16'(`IC_TSU_CYC); // [RQ3]
    end else if ((r.fsm == ST_XFER) ? r.ph[0] : (r.ph != 2'd0)) begin
      lim = r.thi;
    end else begin
      lim = r.tlo;
    end
  end

  // Count seen in the cycle a clear is pending is stale
  assign tdone = t_done && !r.tclr;
  assign hit = ic_match(r.sh, r.own, r.aa);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.tclr = 1'b0;
    next_r.rdata = 16'h0000;

    // Register reads: data stands in the cycle after the strobe only
    if (reg_rd) begin
      if (reg_addr == `IC_OFS_CTL_SET || reg_addr == `IC_OFS_CTL_CLR) begin
        next_r.rdata = {9'h000, r.en, r.begin_condition_request, r.halt_condition_request, r.si, r.aa, 2'b00};
      end else if (reg_addr == `IC_OFS_STAT) begin
        next_r.rdata = {8'h00, (r.si ? r.stat : `IC_STAT_IDLE)};
      end else if (reg_addr == `IC_OFS_DATA) begin
        next_r.rdata = {8'h00, r.dat};
      end else if (reg_addr == `IC_OFS_OWN) begin
        next_r.rdata = {8'h00, r.own};
      end else if (reg_addr == `IC_OFS_SCLH) begin
        next_r.rdata = r.thi;
      end else if (reg_addr == `IC_OFS_SCLL) begin
        next_r.rdata = r.tlo;
      end else begin
        next_r.rdata = 16'h0000;
      end
    end

    // Register writes; the flag can only be set by hardware
    if (reg_wr) begin
      if (reg_addr == `IC_OFS_CTL_SET) begin
        next_r.en = r.en | reg_wdata[`IC_BIT_EN];
        next_r.begin_condition_request = r.begin_condition_request | reg_wdata[`IC_BIT_STA];
        next_r.halt_condition_request = r.halt_condition_request | reg_wdata[`IC_BIT_STO];
        next_r.aa = r.aa | reg_wdata[`IC_BIT_AA];
      end else if (reg_addr == `IC_OFS_CTL_CLR) begin
        next_r.en = r.en & !reg_wdata[`IC_BIT_EN];
        next_r.begin_condition_request = r.begin_condition_request & !reg_wdata[`IC_BIT_STA];
        next_r.halt_condition_request = r.halt_condition_request & !reg_wdata[`IC_BIT_STO];
        next_r.si = r.si & !reg_wdata[`IC_BIT_SI];
        next_r.aa = r.aa & !reg_wdata[`IC_BIT_AA];
      end else if (reg_addr == `IC_OFS_DATA) begin
        next_r.dat = reg_wdata[7:0];
      end else if (reg_addr == `IC_OFS_OWN) begin
        next_r.own = reg_wdata[7:0];
      end else if (reg_addr == `IC_OFS_SCLH) begin
        next_r.thi = reg_wdata;
      end else if (reg_addr == `IC_OFS_SCLL) begin
        next_r.tlo = reg_wdata;
      end
    end

    // ----------------------------------------------------------
    // Engine; hardware flag sets come last so they win over clears
    // ----------------------------------------------------------
    case (r.fsm)
      ST_IDLE: begin
        next_r.scl_drv = 1'b0;
        next_r.sda_drv = 1'b0;
        if (r.halt_condition_request && !r.begin_condition_request) begin
          next_r.halt_condition_request = 1'b0;
        end
        if (r.en && r.begin_condition_request && !ln.busy && !r.si) begin
          next_r.fsm = ST_START; // [RQ17]
          next_r.ph = 2'd2;
          next_r.rep = 1'b0;
          next_r.sda_drv = 1'b1;
          next_r.tclr = 1'b1;
        end else if (r.en && ln.start_seen) begin
          next_r.fsm = ST_XFER; // [RQ7]
          next_r.mst = 1'b0;
          next_r.tx = 1'b0;
          next_r.adr = 1'b1;
          next_r.arb = 1'b0;
          next_r.addr_d = 1'b0;
          next_r.bc = 4'd0;
        end
      end

      // Phases: 0 clock low, 1 clock released, 2 data pulled low
      ST_START: begin
        if (r.ph == 2'd0) begin
          if (tdone) begin
            next_r.ph = 2'd1;
            next_r.scl_drv = 1'b0;
            next_r.tclr = 1'b1;
          end
        end else if (r.ph == 2'd1) begin
          if (!ln.scl) begin
            next_r.tclr = 1'b1;
          end else if (tdone) begin
            next_r.ph = 2'd2;
            next_r.sda_drv = 1'b1;
            next_r.tclr = 1'b1;
          end
        end else if (tdone) begin
          next_r.scl_drv = 1'b1;
          next_r.mst = 1'b1;
          next_r.mrx = 1'b0;
          next_r.stat = r.rep ? `IC_ST_10 : `IC_ST_08; // [RQ18]
          next_r.si = 1'b1;
          next_r.fsm = ST_HOLD;
        end
      end

      // Phases: 0 both low, 1 clock released, 2 data released
      ST_STOP: begin
        if (r.ph == 2'd0) begin
          if (tdone) begin
            next_r.ph = 2'd1;
            next_r.scl_drv = 1'b0;
            next_r.tclr = 1'b1;
          end
        end else if (r.ph == 2'd1) begin
          if (!ln.scl) begin
            next_r.tclr = 1'b1;
          end else if (tdone) begin
            next_r.ph = 2'd2;
            next_r.sda_drv = 1'b0;
            next_r.tclr = 1'b1;
          end
        end else if (tdone) begin
          next_r.halt_condition_request = 1'b0; // [RQ15]
          next_r.mst = 1'b0;
          if (r.begin_condition_request) begin
            next_r.fsm = ST_START; // [RQ16]
            next_r.ph = 2'd2;
            next_r.rep = 1'b0;
            next_r.sda_drv = 1'b1;
            next_r.tclr = 1'b1;
          end else begin
            next_r.fsm = ST_IDLE;
          end
        end
      end

      ST_HOLD: begin
        if (!r.si) begin // [RQ19]
          next_r.ph = 2'd0;
          next_r.tclr = 1'b1;
          next_r.bc = 4'd0;
          if (r.mst) begin
            if (r.halt_condition_request) begin
              next_r.fsm = ST_STOP; // [RQ13] [RQ14] [RQ15]
              next_r.sda_drv = 1'b1;
            end else if (r.begin_condition_request && r.stat != `IC_ST_08 && r.stat != `IC_ST_10) begin
              next_r.fsm = ST_START; // [RQ13] [RQ14]
              next_r.rep = 1'b1;
              next_r.sda_drv = 1'b0;
            end else if (r.stat == `IC_ST_08 || r.stat == `IC_ST_10) begin
              next_r.fsm = ST_XFER;
              next_r.adr = 1'b1;
              next_r.tx = 1'b1;
              next_r.sh = r.dat;
              next_r.mrx = r.dat[0]; // [RQ11]
              next_r.sda_drv = !r.dat[7];
            end else if (r.mrx) begin
              next_r.fsm = ST_XFER;
              next_r.adr = 1'b0;
              next_r.tx = 1'b0;
              next_r.sda_drv = 1'b0;
            end else begin
              next_r.fsm = ST_XFER; // [RQ12] [RQ13] [RQ14]
              next_r.adr = 1'b0;
              next_r.tx = 1'b1;
              next_r.sh = r.dat;
              next_r.sda_drv = !r.dat[7];
            end
          end else if (r.addr_d && r.stat != `IC_ST_C0 && r.stat != `IC_ST_C8 &&
                       r.stat != `IC_ST_88 && r.stat != `IC_ST_98) begin
            next_r.fsm = ST_SETUP;
            if (r.tx) begin
              next_r.sh = r.dat;
              next_r.sda_drv = !r.dat[7];
              next_r.last = !r.aa; // [RQ10]
            end else begin
              next_r.sda_drv = 1'b0;
            end
          end else begin
            next_r.fsm = ST_IDLE; // [RQ10]
            next_r.addr_d = 1'b0;
            next_r.scl_drv = 1'b0;
            next_r.sda_drv = 1'b0;
          end
        end
      end

      // Data sits on the line before the clock is let go
      ST_SETUP: begin
        if (tdone) begin
          next_r.fsm = ST_XFER;
          next_r.scl_drv = 1'b0;
          next_r.adr = 1'b0;
        end
      end

      ST_XFER: begin
        // Master clock: low for the low period, then high period once seen high
        if (r.mst) begin
          if (r.ph == 2'd0) begin
            if (tdone) begin
              next_r.ph = 2'd1;
              next_r.scl_drv = 1'b0;
              next_r.tclr = 1'b1;
            end
          end else if (!ln.scl) begin
            next_r.tclr = 1'b1;
          end else if (tdone) begin
            next_r.ph = 2'd0;
            next_r.scl_drv = 1'b1;
            next_r.tclr = 1'b1;
          end
        end
        if (!r.mst && (ln.start_seen || ln.stop_seen)) begin
          if (r.addr_d && !r.tx) begin
            next_r.stat = `IC_ST_A0;
            next_r.si = 1'b1;
          end
          next_r.addr_d = 1'b0;
          next_r.sda_drv = 1'b0;
          if (ln.start_seen) begin
            next_r.adr = 1'b1;
            next_r.tx = 1'b0;
            next_r.arb = 1'b0;
            next_r.bc = 4'd0;
          end else begin
            next_r.fsm = ST_IDLE;
          end
        end else if (ln.scl_rise) begin
          if (r.bc < 4'd8) begin
            next_r.sh = {r.sh[6:0], ln.sda};
            if (r.mst && r.tx && !r.sda_drv && !ln.sda) begin
              next_r.mst = 1'b0; // [RQ5] [RQ9]
              next_r.tx = 1'b0;
              next_r.arb = 1'b1;
              next_r.scl_drv = 1'b0;
              if (!r.adr) begin
                next_r.stat = `IC_ST_38; // [RQ17]
                next_r.si = 1'b1;
                next_r.fsm = ST_IDLE;
              end
            end
          end else begin
            next_r.ackd = !ln.sda; // [RQ12]
          end
        end else if (ln.scl_fall) begin
          next_r.bc = r.bc + 4'd1;
          if (r.bc < 4'd7) begin
            next_r.sda_drv = r.tx && !r.sh[7];
          end else if (r.bc == 4'd7) begin
            if (r.adr && !r.mst) begin
              if (hit != 2'b00) begin
                next_r.addr_d = 1'b1; // [RQ1] [RQ7]
                next_r.gcall = hit[1];
                next_r.sda_drv = 1'b1;
              end else begin
                next_r.fsm = ST_IDLE;
                next_r.sda_drv = 1'b0;
                if (r.arb) begin
                  next_r.stat = `IC_ST_38;
                  next_r.si = 1'b1;
                end
              end
            end else begin
              next_r.sda_drv = !r.tx && r.aa; // [RQ6]
            end
          end else begin
            // End of acknowledge slot: report and stretch
            next_r.sda_drv = 1'b0;
            next_r.scl_drv = 1'b1; // [RQ20]
            next_r.si = 1'b1;
            next_r.fsm = ST_HOLD;
            next_r.adr = 1'b0;
            if (!r.tx) begin
              next_r.dat = r.sh;
            end
            if (r.mst) begin
              if (r.adr) begin
                next_r.tx = !r.mrx; // [RQ11]
                if (r.mrx) begin
                  next_r.stat = r.ackd ? `IC_ST_40 : `IC_ST_48;
                end else begin
                  next_r.stat = r.ackd ? `IC_ST_18 : `IC_ST_20;
                end
              end else if (r.tx) begin
                next_r.stat = r.ackd ? `IC_ST_28 : `IC_ST_30; // [RQ14]
              end else begin
                next_r.stat = r.ackd ? `IC_ST_50 : `IC_ST_58;
              end
            end else if (r.adr) begin
              next_r.dat = r.sh;
              next_r.tx = r.sh[0];
              if (r.gcall) begin
                next_r.stat = r.arb ? `IC_ST_78 : `IC_ST_70; // [RQ5]
              end else if (r.sh[0]) begin
                next_r.stat = r.arb ? `IC_ST_B0 : `IC_ST_A8; // [RQ8] [RQ9]
              end else begin
                next_r.stat = r.arb ? `IC_ST_68 : `IC_ST_60; // [RQ4] [RQ5]
              end
            end else if (r.tx) begin
              if (r.ackd) begin
                next_r.stat = r.last ? `IC_ST_C8 : `IC_ST_B8; // [RQ10]
              end else begin
                next_r.stat = `IC_ST_C0; // [RQ10]
              end
            end else if (r.gcall) begin
              next_r.stat = r.ackd ? `IC_ST_90 : `IC_ST_98;
            end else begin
              next_r.stat = r.ackd ? `IC_ST_80 : `IC_ST_88; // [RQ6]
            end
          end
        end
      end

      default: begin
        next_r.fsm = ST_IDLE;
      end
    endcase

    // Disabled block lets go of both lines at once
    if (!r.en) begin
      next_r.fsm = ST_IDLE;
      next_r.scl_drv = 1'b0;
      next_r.sda_drv = 1'b0;
      next_r.mst = 1'b0;
      next_r.addr_d = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      r <= '{fsm: ST_IDLE, ph: 2'd0, bc: 4'd0, sh: 8'h00, stat: `IC_STAT_IDLE,
             dat: 8'h00, own: `IC_RST_OWN, thi: `IC_RST_SCL, tlo: `IC_RST_SCL,
             rdata: 16'h0000, default: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Pins and read data
  // ------------------------------------------------------------
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = r.scl_drv;
  assign sda_oe = r.sda_drv;
  assign reg_rdata = r.rdata;
endmodule : ic_top
`default_nettype wire

// ===== verification/ic_slave_model.sv
// Behavioural I2C slave that acks one address
`default_nettype none
module ic_slave_model #(
  parameter logic [6:0] slave_addr = 7'h52
) (
  // Resolved lines
  input wire logic scl,
  input wire logic sda,
  // Data pull-down
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic hdr = 1'b0;
  logic act = 1'b0;
  int n = 0;
  initial sda_oe = 1'b0;
  // ---
  // Framing
  // ---
  always @(negedge sda) if (scl) begin
    n = 0;
    hdr = 1'b1;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    n = n + 1;
  end
  // Changes only with the clock low, so never a false start or stop
  always @(negedge scl) begin
    if (n == 8 && hdr) act = sh[7:1] == slave_addr && !sh[0];
    if (n == 8) hdr = 1'b0;
    sda_oe <= n == 8 && act;
    if (n == 9) n = 0;
  end
endmodule : ic_slave_model
`default_nettype wire

// ===== verification/ic_top_chk.sv
// Port assertions of the I2C engine
`default_nettype none
module ic_top_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ---
  // Steps
  // ---
  // Idle middle cycle, as a write there would spoil the readback
  sequence own_wr_rd;
    (reg_wr && reg_addr == 5'h0C) ##1 !reg_wr ##1 (reg_rd && reg_addr == 5'h0C);
  endsequence
  sequence aa_wr_rd;
    (reg_wr && reg_addr == 5'h00 && reg_wdata[2]) ##1 !reg_wr ##1
      (reg_rd && reg_addr == 5'h00);
  endsequence
  sequence dev_start;
    $rose(sda_oe) && !scl_oe && scl_in;
  endsequence
  // ---
  // Checks
  // ---
  rd_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its slot");
  own_back_a: assert property (own_wr_rd |=>
      reg_rdata == ($past(reg_wdata, 3) & 16'h00FF)) else $error("own address lost");
  aa_kept_a: assert property (aa_wr_rd |=> reg_rdata[2])
    else $error("ack assert lost");
  unmap_rd_a: assert property (reg_rd && reg_addr == 5'h1C |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  scl_od_a: assert property (scl_out == 1'b0) else $error("scl driven high");
  sda_od_a: assert property (sda_out == 1'b0) else $error("sda driven high");
  start_hold_a: assert property (dev_start |-> ##[1:1000] scl_oe)
    else $error("no clock hold after start");
  // Enable drops one edge after the write, the pins follow one edge later
  dis_rel_a: assert property (reg_wr && reg_addr == 5'h18 && reg_wdata[6] |=> ##1
      (!scl_oe && !sda_oe)) else $error("lines kept after disable");
endmodule : ic_top_chk
bind ic_top ic_top_chk u_ic_top_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// ===== verification/ic_top_tb.sv
// Self-checking bench of the I2C engine
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module ic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic scl_oe, sda_oe, m_sda_oe, scl_out, sda_out;
  // Both ends only pull low; pull-ups idle the wires high
  wire logic scl = !scl_oe;
  wire logic sda = !(sda_oe || m_sda_oe);
  int mismatches = 0, cmp_count = 0, cyc = 0;
  // Address beside reset value; 0x1C is unmapped
  logic [20:0] rows [8] = '{{5'h00, 16'h0000}, {5'h04, 16'h00F8}, {5'h08, 16'h0000},
    {5'h0C, 16'h0000}, {5'h10, 16'h0271}, {5'h14, 16'h0271}, {5'h18, 16'h0000},
    {5'h1C, 16'h0000}};
  ic_top u_ic_top (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe));
  ic_slave_model u_ic_slave_model (.scl(scl), .sda(sda), .sda_oe(m_sda_oe));
  always #4 clk_sys = !clk_sys;
  // Run needs about 700 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  // ---
  // Tasks
  // ---
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wait_bit(input int b, input logic v);
    repeat (300) begin
      rd(5'h00);
      if (d[b] === v) break;
    end
  endtask : wait_bit
  task automatic go(input logic [4:0] a, input logic [15:0] v, input logic [7:0] st);
    wr(a, v);
    wait_bit(3, 1'b1);
    rd(5'h04);
    `CHK(d, {8'h00, st})
  endtask : go
  task automatic check_rows();
    foreach (rows[i]) begin
      rd(rows[i][20:16]);
      `CHK(d, rows[i][15:0])
    end
  endtask : check_rows
  // ---
  // Sequence
  // ---
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check_rows();
    $display("reset values done");
    // Counts of 5 give a bit time near 128 ns (16 clocks)
    wr(5'h10, 16'h0005);
    wr(5'h14, 16'h0005);
    wr(5'h0C, 16'h0023);
    rd(5'h0C);
    `CHK(d, 16'h0023)
    wr(5'h00, 16'h0044);
    rd(5'h00);
    `CHK(d, 16'h0044)
    go(5'h00, 16'h0020, 8'h08);
    wr(5'h08, 16'h00A4);
    go(5'h18, 16'h0028, 8'h18);
    wr(5'h08, 16'h005A);
    go(5'h18, 16'h0008, 8'h28);
    wr(5'h00, 16'h0030);
    go(5'h18, 16'h0008, 8'h08);
    wr(5'h08, 16'h0060);
    go(5'h18, 16'h0028, 8'h20);
    wr(5'h00, 16'h0010);
    wr(5'h18, 16'h0008);
    wait_bit(4, 1'b0);
    `CHK(d, 16'h0044)
    $display("master transmit done");
    wr(5'h00, 16'h0020);
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b0;
    #1 `CHK({scl_oe, sda_oe}, 2'b00)
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check_rows();
    $display("second reset done");
    // Disable while a start holds both lines low
    wr(5'h10, 16'h0005);
    wr(5'h00, 16'h0064);
    wait_bit(3, 1'b1);
    `CHK({scl_oe, sda_oe}, 2'b11)
    wr(5'h18, 16'h0068);
    rd(5'h00);
    `CHK(d, 16'h0004)
    `CHK({scl_oe, sda_oe}, 2'b00)
    $display("disable done");
    print_verdict();
  end
endmodule : ic_top_tb
`default_nettype wire
